// ==== shared/cits_defs.svh ====
`ifndef CITS_DEFS_SVH
`define CITS_DEFS_SVH

`define CITS_TRAP_VECTOR 16'h0000
`define CITS_NMI_VECTOR 16'h0066
`define CITS_OP_RST_MASK 8'hC7
`define CITS_OP_RST 8'hC7
`define CITS_OP_CALL 8'hCD
`define CITS_RST_TGT_MASK 8'h38
`define CITS_WAIT_FIELD_W 2
`define CITS_CLOCK_PERIOD_NS 10
`define CITS_RESET_LEAD_CLOCKS 5
`define CITS_WAIT_SETTLE 2'h3

`endif

// ==== shared/cits_pkg.sv ====
package cits_pkg;

    typedef enum logic [1:0] {
        CITS_REV_EARLY = 2'h0,
        CITS_REV_LATER = 2'h1
    } cits_rev_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic irq_mode_bus;
        logic [1:0] ack_wait_sel;
    } cits_irq_cfg_t;

    typedef struct packed {
        logic push;
        logic [15:0] push_addr;
        logic jump;
        logic [15:0] jump_addr;
    } cits_ctl_out_t;

endpackage

// ==== rtl/cits_sync.sv ====
`timescale 1ns/1ps
module cits_sync
    import cits_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_async,
    output logic o_sync
);
    typedef struct packed {
        logic s1;
        logic s2;
    } cits_sync_state_t;

    cits_sync_state_t state;
    cits_sync_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.s1 = i_async;
        next_state.s2 = state.s1;
    end

    // Reset to high: inactive level for the active-low lines
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= 2'h3;
        end else begin
            state <= next_state;
        end
    end

    assign o_sync = state.s2;
endmodule

// ==== rtl/cits_core.sv ====
`timescale 1ns/1ps
`include "cits_defs.svh"
// Contract
// - In bus-instruction irq mode, execute opcode the peripheral drives during acknowledge.
// - Hold PC at return address during first acknowledge opcode fetch.
// - Restart opcode pushes unmodified return address, branches to restart target.
// - Call opcode advances PC per operand byte; pushed value is return plus 2.
// - Any other supplied opcode pushes nothing during acknowledge.
// - Two-bit wait field lengthens the maskable acknowledge cycle.
// - Early revision: reset released while external wait low fails to restart.
// - Reset low five clocks before wait low restarts correctly; the early revision here still locks whenever wait is low at release.
// - Reset during internal-only wait states restarts correctly.
// - Undefined opcode fetch raises trap vectoring to 0000H.
// - Early revision: falling nonmaskable edge in window vectors trap to 0066H.
// - Pending nonmaskable runs after one opcode at 0066H, vectoring there again.
// - Same conflict whether second or third opcode byte is undefined.
module cits_core
    import cits_pkg::*;
#(
    parameter cits_rev_t REVISION = CITS_REV_EARLY
) (
    input wire logic I_CLOCK,
    input wire logic I_RESET_N,
    input wire logic I_EXTERNAL_MASKABLE_IRQ_LINE_N,
    input wire logic I_NMI_N,
    input wire logic I_WAIT_N,
    input wire logic I_IRQ_MODE_BUS,
    input wire logic I_IRQ_ACK_WAIT_SEL_LO,
    input wire logic I_IRQ_ACK_WAIT_SEL_HI,
    input wire logic I_INT_ENABLE,
    input wire logic [7:0] I_DATA,
    input wire logic [15:0] I_PC,
    input wire logic I_FETCH_DONE,
    input wire logic I_UNDEF_OPCODE,
    input wire logic I_CRIT_WINDOW,
    input wire logic I_INT_WAIT_ACTIVE,
    output logic O_IRQ_ACK,
    output logic O_PC_HOLD,
    output logic O_PC_INC,
    output logic O_PUSH,
    output logic [15:0] O_PUSH_ADDR,
    output logic O_JUMP,
    output logic [15:0] O_JUMP_ADDR,
    output logic O_NMI_ACK,
    output logic O_TRAP_ACK,
    output logic O_RUNNING
);
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [7:0] {
        ST_RUN = 8'h01,
        ST_ACK_WAIT = 8'h02,
        ST_ACK_FETCH = 8'h04,
        ST_OPND_LO = 8'h08,
        ST_OPND_HI = 8'h10,
        ST_VECTOR = 8'h20,
        ST_STUCK = 8'h40,
        ST_NMI_STEP = 8'h80
    } cits_state_t;

    typedef struct packed {
        cits_state_t fsm;
        logic [1:0] wait_cnt;
        logic [15:0] ret_addr;
        logic [7:0] opcode;
        logic [7:0] opnd_lo;
        logic nmi_prev;
        logic nmi_pending;
        logic [1:0] settle;
        logic push;
        logic [15:0] push_addr;
        logic jump;
        logic [15:0] jump_addr;
        logic nmi_ack;
        logic trap_ack;
        logic irq_ack;
    } cits_core_state_t;

    cits_core_state_t state;
    cits_core_state_t next_state;
    logic irq_n_s;
    logic nmi_n_s;
    logic wait_n_s;
    logic nmi_fall;
    logic is_rst;
    logic is_call;

    ////////////////////////////////////////////////////////////////////////////
    // Pins cross in through two flops each
    cits_sync u_sync_irq (
        .i_clock(I_CLOCK),
        .i_reset_n(I_RESET_N),
        .i_async(I_EXTERNAL_MASKABLE_IRQ_LINE_N),
        .o_sync(irq_n_s)
    );
    cits_sync u_sync_nmi (
        .i_clock(I_CLOCK),
        .i_reset_n(I_RESET_N),
        .i_async(I_NMI_N),
        .o_sync(nmi_n_s)
    );
    cits_sync u_sync_wait (
        .i_clock(I_CLOCK),
        .i_reset_n(I_RESET_N),
        .i_async(I_WAIT_N),
        .o_sync(wait_n_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    assign nmi_fall = state.nmi_prev && !nmi_n_s;
    assign is_rst = (state.opcode & `CITS_OP_RST_MASK) == `CITS_OP_RST;
    assign is_call = state.opcode == `CITS_OP_CALL;

    always_comb begin
        next_state = state;
        next_state.push = 1'b0;
        next_state.jump = 1'b0;
        next_state.nmi_ack = 1'b0;
        next_state.trap_ack = 1'b0;
        next_state.irq_ack = 1'b0;
        next_state.nmi_prev = nmi_n_s;
        next_state.settle = (state.settle != 2'h0) ? state.settle - 2'h1 : 2'h0;
        if (nmi_fall) begin
            next_state.nmi_pending = 1'b1;
        end
        // Judged once the wait synchroniser has flushed its reset level
        if (state.settle == 2'h1 && REVISION == CITS_REV_EARLY && !wait_n_s) begin
            next_state.fsm = ST_STUCK;
        end else begin
            case (state.fsm)
                ST_RUN: begin
                    if (I_UNDEF_OPCODE && I_FETCH_DONE) begin
                        // Stack the undefined opcode address, either byte position
                        next_state.push = 1'b1;
                        next_state.push_addr = I_PC;
                        next_state.jump = 1'b1;
                        next_state.trap_ack = 1'b1;
                        if (REVISION == CITS_REV_EARLY && I_CRIT_WINDOW && nmi_fall) begin
                            next_state.jump_addr = `CITS_NMI_VECTOR;
                            next_state.fsm = ST_NMI_STEP;
                        end else begin
                            next_state.jump_addr = `CITS_TRAP_VECTOR;
                        end
                    end else if (state.nmi_pending && I_FETCH_DONE) begin
                        next_state.nmi_pending = nmi_fall;
                        next_state.nmi_ack = 1'b1;
                        next_state.push = 1'b1;
                        next_state.push_addr = I_PC;
                        next_state.jump = 1'b1;
                        next_state.jump_addr = `CITS_NMI_VECTOR;
                    end else if (!irq_n_s && I_INT_ENABLE && I_IRQ_MODE_BUS && I_FETCH_DONE) begin
                        next_state.ret_addr = I_PC;
                        next_state.wait_cnt = {I_IRQ_ACK_WAIT_SEL_HI, I_IRQ_ACK_WAIT_SEL_LO};
                        next_state.fsm = ST_ACK_WAIT;
                    end
                end
                ST_ACK_WAIT: begin
                    next_state.irq_ack = 1'b1;
                    if (state.wait_cnt == 2'h0 && wait_n_s) begin
                        next_state.fsm = ST_ACK_FETCH;
                    end else if (state.wait_cnt != 2'h0) begin
                        next_state.wait_cnt = state.wait_cnt - 2'h1;
                    end
                end
                ST_ACK_FETCH: begin
                    next_state.opcode = I_DATA;
                    next_state.fsm = ((I_DATA & `CITS_OP_RST_MASK) == `CITS_OP_RST
                        || I_DATA != `CITS_OP_CALL) ? ST_VECTOR : ST_OPND_LO;
                end
                ST_OPND_LO: begin
                    next_state.opnd_lo = I_DATA;
                    next_state.ret_addr = state.ret_addr + 16'h0001;
                    next_state.fsm = ST_OPND_HI;
                end
                ST_OPND_HI: begin
                    next_state.ret_addr = state.ret_addr + 16'h0001;
                    next_state.jump_addr = {I_DATA, state.opnd_lo};
                    next_state.push_addr = state.ret_addr + 16'h0001;
                    next_state.push = 1'b1;
                    next_state.jump = 1'b1;
                    next_state.fsm = ST_RUN;
                end
                ST_VECTOR: begin
                    if (is_rst) begin
                        next_state.push = 1'b1;
                        next_state.push_addr = state.ret_addr;
                        next_state.jump = 1'b1;
                        next_state.jump_addr = {8'h00, state.opcode & `CITS_RST_TGT_MASK};
                    end
                    // Other opcodes run through the normal path, nothing stacked
                    next_state.fsm = ST_RUN;
                end
                ST_NMI_STEP: begin
                    // One opcode at the vector runs before the pending request
                    if (I_FETCH_DONE) begin
                        next_state.fsm = ST_RUN;
                    end
                end
                ST_STUCK: begin
                    next_state.fsm = ST_STUCK;
                end
                default: begin
                    next_state.fsm = ST_RUN;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers reset high, so the wait pin is only trusted on the third edge
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state <= '0;
            state.fsm <= ST_RUN;
            state.nmi_prev <= 1'b1;
            state.settle <= `CITS_WAIT_SETTLE;
        end else begin
            state <= next_state;
        end
    end

    assign O_IRQ_ACK = state.irq_ack;
    assign O_PC_HOLD = state.fsm == ST_ACK_WAIT || state.fsm == ST_ACK_FETCH;
    assign O_PC_INC = state.fsm == ST_OPND_LO || state.fsm == ST_OPND_HI;
    assign O_PUSH = state.push;
    assign O_PUSH_ADDR = state.push_addr;
    assign O_JUMP = state.jump;
    assign O_JUMP_ADDR = state.jump_addr;
    assign O_NMI_ACK = state.nmi_ack;
    assign O_TRAP_ACK = state.trap_ack;
    assign O_RUNNING = state.fsm != ST_STUCK;
endmodule

// ==== sim/cits_core_sva.sv ====
`timescale 1ns/1ps
module cits_core_sva (
    input logic I_CLOCK,
    input logic I_RESET_N,
    input logic I_NMI_N,
    input logic I_IRQ_ACK_WAIT_SEL_LO,
    input logic I_IRQ_ACK_WAIT_SEL_HI,
    input logic [7:0] I_DATA,
    input logic I_FETCH_DONE,
    input logic I_UNDEF_OPCODE,
    input logic I_CRIT_WINDOW,
    input logic O_IRQ_ACK,
    input logic O_PC_HOLD,
    input logic O_PC_INC,
    input logic O_PUSH,
    input logic O_JUMP,
    input logic [15:0] O_JUMP_ADDR,
    input logic O_NMI_ACK,
    input logic O_RUNNING
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESET_N);
    ////////////////////////////////////////
    // Ack end is the fetch boundary; the model keeps the opcode on the bus past it
    sequence s_ack_end;
        $fell(O_IRQ_ACK);
    endsequence
    property p_hold;
        O_IRQ_ACK |-> O_PC_HOLD && !O_PC_INC;
    endproperty
    a_hold: assert property (p_hold) else $error("pc moves in ack");
    property p_rst;
        s_ack_end ##0 ((I_DATA & 8'hC7) == 8'hC7)
            |-> ##[1:4] (O_PUSH && O_JUMP && O_JUMP_ADDR == {8'h00, I_DATA & 8'h38});
    endproperty
    a_rst: assert property (p_rst) else $error("restart not taken");
    property p_call;
        s_ack_end ##0 (I_DATA == 8'hCD) |-> ##[1:6] O_PUSH;
    endproperty
    a_call: assert property (p_call) else $error("call not pushed");
    property p_other;
        s_ack_end ##0 (I_DATA == 8'h00) |-> !O_PUSH [*6];
    endproperty
    a_other: assert property (p_other) else $error("push on plain opcode");
    property p_wait;
        $rose(O_IRQ_ACK) && I_IRQ_ACK_WAIT_SEL_LO && I_IRQ_ACK_WAIT_SEL_HI |-> O_IRQ_ACK [*3];
    endproperty
    a_wait: assert property (p_wait) else $error("ack too short");
    property p_lock;
        !O_RUNNING |=> !O_RUNNING;
    endproperty
    a_lock: assert property (p_lock) else $error("lock left without reset");
    property p_trap;
        I_FETCH_DONE && I_UNDEF_OPCODE && !I_CRIT_WINDOW && I_NMI_N && O_RUNNING
            |-> ##[1:6] (O_JUMP && O_JUMP_ADDR == 16'h0000);
    endproperty
    a_trap: assert property (p_trap) else $error("trap vector wrong");
    property p_nmi;
        $fell(I_NMI_N) |-> ##[2:60] O_NMI_ACK;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi edge lost");
endmodule
bind cits_core cits_core_sva i_sva (.*);

// ==== sim/cits_periph.sv ====
`timescale 1ns/1ps
module cits_periph (
    input wire logic i_clock,
    input wire logic i_irq_ack,
    input wire logic [7:0] i_opcode,
    output logic [7:0] o_data
);
    logic [3:0] hold = 4'h0;
    logic [7:0] last = 8'h5A;
    // From eight cycles after the acknowledge the bus flips each cycle, so stale data never passes
    always_ff @(posedge i_clock) begin
        hold <= i_irq_ack ? 4'h8 : (hold != 4'h0 ? hold - 4'h1 : 4'h0);
        last <= o_data;
    end
    assign o_data = (i_irq_ack || hold != 4'h0) ? i_opcode : ~last;
endmodule

// ==== sim/cits_core_tb.sv ====
`timescale 1ns/1ps
module cits_core_tb;
    import cits_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, irq_n = 1'b1, nmi_n = 1'b1, wait_n = 1'b1, en = 1'b1;
    logic mode = 1'b1, lo = 1'b0, hi = 1'b0, fd = 1'b0, undef = 1'b0, crit = 1'b0, iwa = 1'b0;
    logic ack, hold, inc, push, jump, nack, tack, run;
    logic [7:0] op = 8'h00;
    logic [7:0] data;
    logic [15:0] pc = 16'h1234;
    logic [15:0] pa, ja, got_p, got_j;
    int n_fail = 0;
    int n_checks = 0;
    int acks, pushes, tr, nm;
    always #5 clk = ~clk;
    // Outside PC; the core only says when an operand byte moves it on
    always @(posedge clk) if (inc) pc <= pc + 16'h0001;
    cits_core #(.REVISION(CITS_REV_EARLY)) i_dut (.I_CLOCK(clk), .I_RESET_N(rst_n),
        .I_EXTERNAL_MASKABLE_IRQ_LINE_N(irq_n), .I_NMI_N(nmi_n), .I_WAIT_N(wait_n),
        .I_IRQ_MODE_BUS(mode), .I_IRQ_ACK_WAIT_SEL_LO(lo), .I_IRQ_ACK_WAIT_SEL_HI(hi),
        .I_INT_ENABLE(en), .I_DATA(data), .I_PC(pc), .I_FETCH_DONE(fd),
        .I_UNDEF_OPCODE(undef), .I_CRIT_WINDOW(crit), .I_INT_WAIT_ACTIVE(iwa),
        .O_IRQ_ACK(ack), .O_PC_HOLD(hold), .O_PC_INC(inc), .O_PUSH(push), .O_PUSH_ADDR(pa),
        .O_JUMP(jump), .O_JUMP_ADDR(ja), .O_NMI_ACK(nack), .O_TRAP_ACK(tack), .O_RUNNING(run));
    cits_periph i_model (.i_clock(clk), .i_irq_ack(ack), .i_opcode(op), .o_data(data));
    ////////////////////////////////////////
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic boundary();
        fd = 1'b1;
        step(1);
        fd = 1'b0;
    endtask
    // Fixed observation window; nothing here waits on the design
    task automatic watch(input int n);
        {acks, pushes, tr, nm} = '0;
        {got_p, got_j} = 'x;
        // Sample first: a pulse launched at the boundary edge stands only now
        repeat (n) begin
            acks += int'(ack);
            pushes += int'(push);
            tr += int'(tack);
            nm += int'(nack);
            if (push) got_p = pa;
            if (jump) got_j = ja;
            @(negedge clk);
        end
    endtask
    ////////////////////////////////////////
    task automatic t_irq(input logic [7:0] o, input logic [1:0] s, input int np,
                         input logic [15:0] ep, input logic [15:0] ej);
        op = o;
        {hi, lo} = s;
        pc = 16'h1234;
        irq_n = 1'b0;
        step(3);
        boundary();
        watch(24);
        irq_n = 1'b1;
        chk(acks == int'(s) + 1, "ack length");
        chk(pushes == np, "push count");
        chk(pc === (o == 8'hCD ? 16'h1236 : 16'h1234), "pc steps");
        step(1);
        if (np > 0) chk(got_p === ep && got_j === ej, "stack or target");
        $display("irq test %h done", o);
    endtask
    task automatic t_refuse();
        mode = 1'b0;
        irq_n = 1'b0;
        step(3);
        boundary();
        watch(12);
        chk(acks == 0 && pushes == 0, "irq taken outside bus mode");
        irq_n = 1'b1;
        mode = 1'b1;
        $display("refusal test done");
    endtask
    task automatic t_trap(input logic w);
        pc = 16'h0200;
        crit = w;
        step(1);
        // Two sync flops: the edge lands on the fetch edge
        nmi_n = ~w;
        step(2);
        undef = 1'b1;
        boundary();
        undef = 1'b0;
        crit = 1'b0;
        watch(10);
        chk(tr > 0 && got_p === 16'h0200, "trap stack");
        chk(got_j === (w ? 16'h0066 : 16'h0000), "trap vector");
        if (w) begin
            pc = 16'h0066;
            boundary();
            watch(8);
            chk(nm == 0, "nmi taken too early");
            pc = 16'h0067;
            boundary();
            watch(10);
            chk(nm > 0 && got_p === 16'h0067 && got_j === 16'h0066, "nmi stack");
            nmi_n = 1'b1;
        end
        $display("trap test %b done", w);
    endtask
    task automatic t_reset();
        rst_n = 1'b0;
        step(5);
        wait_n = 1'b0;
        step(3);
        rst_n = 1'b1;
        step(5);
        chk(run === 1'b0, "restart despite wait");
        rst_n = 1'b0;
        step(5);
        wait_n = 1'b1;
        step(3);
        rst_n = 1'b1;
        step(5);
        chk(run === 1'b1, "no restart");
        iwa = 1'b1;
        rst_n = 1'b0;
        step(3);
        rst_n = 1'b1;
        iwa = 1'b0;
        step(5);
        chk(run === 1'b1, "no restart after internal wait");
        $display("reset test done");
    endtask
    ////////////////////////////////////////
    initial begin
        step(3);
        rst_n = 1'b1;
        step(2);
        for (int k = 0; k < 8; k++) begin
            t_irq(8'hC7 | 8'(k << 3), 2'(k), 1, 16'h1234, 16'(k << 3));
        end
        t_irq(8'hCD, 2'h3, 1, 16'h1236, 16'hCDCD);
        t_irq(8'h00, 2'h1, 0, 16'h0000, 16'h0000);
        t_refuse();
        t_trap(1'b0);
        t_trap(1'b1);
        t_reset();
        end_sim();
    end
    initial begin
        #200000;
        n_fail++;
        end_sim();
    end
endmodule
